// ==== pfa_program_fetch.v ====
// Program counter, program and data EEPROM addressing, cycle clock
// How it works
// - Separate program and data buses, concurrent access
// - Thirteen-bit program counter, 8K-word space
// - Only lowest 1K words physically stored
// - Upper counter bits ignored, addresses wrap
// - Any reset restarts fetch at zero
// - Taken interrupt loads counter with four
// - EEPROM reached only through pointer register
// - EEPROM holds 64 bytes, pointer 0-3F
// - Instruction cycle is quarter oscillator rate
// - Low master clear holds device reset
// - Each program word is 14 bits
`timescale 1ns/10ps
`default_nettype none
`include "pfa_regs.vh"
module pfa_program_fetch #(
	parameter PCW = `PFA_PC_WIDTH,
	parameter IW = `PFA_WORD_WIDTH,
	parameter IAW = `PFA_IMPL_AWIDTH,
	parameter EAW = `PFA_EE_AWIDTH,
	parameter DW = `PFA_DATA_WIDTH
) (
	// Clock and resets
	input wire sys_clk,
	input wire srst,
	input wire master_clear_n,
	// Oscillator mode select, high for resistor-capacitor
	input wire rcMode,
	// Core control
	input wire irqTake,
	input wire branchEn,
	input wire [PCW-1:0] branchAddr,
	// Program storage load port
	input wire progWrEn,
	input wire [IAW-1:0] progWrAddr,
	input wire [IW-1:0] progWrData,
	// Data EEPROM pointer port
	input wire eePtrWrEn,
	input wire [EAW-1:0] eePtrData,
	input wire eeWrEn,
	input wire [DW-1:0] eeWrData,
	// Outputs
	output reg [PCW-1:0] pcOut,
	output reg [IW-1:0] instrWord,
	output reg instrValid,
	output reg [DW-1:0] eeRdData,
	output reg osc_out,
	output reg instr_cycle_clock_out
);
	////////////////////////////////////////////////////////////////
	// Reset and clock divider
	////////////////////////////////////////////////////////////////
	// Combined reset from system and master clear pin
	wire rstAll;
	assign rstAll = srst | ~master_clear_n;

	// Quarter-rate phase counter
	reg [`PFA_PHASE_WIDTH-1:0] phase_q;
	// One-cycle enable at end of each instruction cycle
	wire cycleEn;
	assign cycleEn = (phase_q == `PFA_PHASE_LAST);

	// Phase counter process
	always @(posedge sys_clk) begin
		if (rstAll) begin
			phase_q <= {`PFA_PHASE_WIDTH{1'b0}};
		end else begin
			phase_q <= phase_q + 2'h1;
		end
	end

	// Cycle clock output, high for first half of each cycle
	always @(posedge sys_clk) begin
		if (rstAll) begin
			instr_cycle_clock_out <= 1'b0;
			osc_out <= 1'b0;
		end else begin
			instr_cycle_clock_out <= (phase_q + 2'h1) < `PFA_PHASE_HALF;
			// Oscillator pin carries cycle clock only in RC mode
			osc_out <= rcMode & ((phase_q + 2'h1) < `PFA_PHASE_HALF);
		end
	end

	////////////////////////////////////////////////////////////////
	// Program counter
	////////////////////////////////////////////////////////////////
	// Current counter and next value
	reg [PCW-1:0] pc_q;
	reg [PCW-1:0] pc_d;

	// Next counter selection: interrupt, branch, then increment
	always @* begin
		pc_d = pc_q;
		if (cycleEn) begin
			if (irqTake) begin
				pc_d = `PFA_IRQ_VECTOR;
			end else if (branchEn) begin
				pc_d = branchAddr;
			end else begin
				pc_d = pc_q + 13'h0001;
			end
		end
	end

	// Counter register
	always @(posedge sys_clk) begin
		if (rstAll) begin
			pc_q <= `PFA_RESET_VECTOR;
		end else begin
			pc_q <= pc_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Program storage on its own bus
	////////////////////////////////////////////////////////////////
	// Implemented 1K x 14 words
	reg [IW-1:0] progMem [0:(1<<IAW)-1];

	// Fetch index drops upper counter bits so aliases wrap
	wire [IAW-1:0] fetchIdx;
	assign fetchIdx = pc_q[IAW-1:0];

	// Program load write, no reset on array contents
	always @(posedge sys_clk) begin
		if (progWrEn) begin
			progMem[progWrAddr] <= progWrData;
		end
	end

	// Fetch register, one word per instruction cycle
	always @(posedge sys_clk) begin
		if (rstAll) begin
			instrWord <= {IW{1'b0}};
			instrValid <= 1'b0;
			pcOut <= `PFA_RESET_VECTOR;
		end else begin
			instrValid <= cycleEn;
			pcOut <= pc_q;
			if (cycleEn) begin
				instrWord <= progMem[fetchIdx];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Data EEPROM on the data bus, pointer only
	////////////////////////////////////////////////////////////////
	// Address pointer register
	reg [EAW-1:0] eePtr_q;

	// Pointer load
	always @(posedge sys_clk) begin
		if (rstAll) begin
			eePtr_q <= {EAW{1'b0}};
		end else if (eePtrWrEn) begin
			eePtr_q <= eePtrData;
		end
	end

	// Store read data
	wire [DW-1:0] eeRaw;

	// Byte store instance
	pfa_ee_store #(
		.AW(EAW),
		.DW(DW),
		.DEPTH(1<<EAW)
	) uEe (
		.sys_clk(sys_clk),
		.ptr(eePtr_q),
		.wrData(eeWrData),
		.wrEn(eeWrEn & ~rstAll),
		.rdData(eeRaw)
	);

	// Data bus output register, independent of fetch
	always @(posedge sys_clk) begin
		if (rstAll) begin
			eeRdData <= {DW{1'b0}};
		end else begin
			eeRdData <= eeRaw;
		end
	end
endmodule // pfa_program_fetch
`default_nettype wire

// ==== pfa_regs.vh ====
// Constants for the program fetch and addressing block
`ifndef PFA_REGS_VH
`define PFA_REGS_VH
`define PFA_PC_WIDTH 13
`define PFA_WORD_WIDTH 14
`define PFA_IMPL_AWIDTH 10
`define PFA_IMPL_WORDS 1024
`define PFA_RESET_VECTOR 13'h0000
`define PFA_IRQ_VECTOR 13'h0004
`define PFA_EE_AWIDTH 6
`define PFA_EE_BYTES 64
`define PFA_EE_TOP 6'h3F
`define PFA_DATA_WIDTH 8
`define PFA_CLK_DIV 4
`define PFA_PHASE_WIDTH 2
`define PFA_PHASE_LAST 2'h3
`define PFA_PHASE_HALF 2'h2
`endif

// ==== pfa_ee_store.v ====
// Data EEPROM byte store reached through an address pointer
`timescale 1ns/10ps
`default_nettype none
`include "pfa_regs.vh"
module pfa_ee_store #(
	parameter AW = `PFA_EE_AWIDTH,
	parameter DW = `PFA_DATA_WIDTH,
	parameter DEPTH = `PFA_EE_BYTES
) (
	// Clock
	input wire sys_clk,
	// Access
	input wire [AW-1:0] ptr,
	input wire [DW-1:0] wrData,
	input wire wrEn,
	output reg [DW-1:0] rdData
);
	// Byte array, only reachable by pointer
	reg [DW-1:0] mem [0:DEPTH-1];

	// Write and registered read of the pointed byte, a same-cycle read returns the old byte
	always @(posedge sys_clk) begin
		if (wrEn) begin
			mem[ptr] <= wrData;
		end
		rdData <= mem[ptr];
	end
endmodule // pfa_ee_store
`default_nettype wire

// ==== pfa_prog_loader.sv ====
// Far-side model that fills program storage with a known image
`timescale 1ns/10ps
`default_nettype none
module pfa_prog_loader (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Program load port
	output logic progWrEn,
	output logic [9:0] progWrAddr,
	output logic [13:0] progWrData
);
	logic [10:0] cnt_q; // Next word to load
	initial cnt_q = 11'h000;
	// One word per clock after reset, only the stored 1K region
	always @(posedge sys_clk) begin
		if (!srst && !cnt_q[10]) cnt_q <= cnt_q + 11'h001;
	end
	assign progWrEn = !srst && !cnt_q[10];
	assign progWrAddr = cnt_q[9:0];
	assign progWrData = {cnt_q[3:0], cnt_q[9:0]};
endmodule // pfa_prog_loader
`default_nettype wire

// ==== pfa_fetch_monitor.sv ====
// Checker for the program fetch block
`timescale 1ns/10ps
`default_nettype none
module pfa_fetch_mon (
	// Clock, resets and controls
	input wire logic sys_clk, srst, master_clear_n, rcMode, irqTake, branchEn,
	// Branch target and observed outputs
	input wire logic [12:0] branchAddr, pcOut,
	input wire logic [13:0] instrWord,
	input wire logic instrValid, osc_out, instr_cycle_clock_out
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst || !master_clear_n);
	sequence s_plain; !irqTake && !branchEn ##1 instrValid; endsequence
	sequence s_irq; irqTake ##1 instrValid; endsequence
	property p_reset; disable iff (1'b0) srst || !master_clear_n |=> pcOut == 13'h0000 && !instrValid;
	endproperty
	property p_first; $fell(srst) |-> ##[1:6] instrValid && pcOut == 13'h0000; endproperty
	property p_step; s_plain |=> pcOut == $past(pcOut) + 13'h0001; endproperty
	property p_irq; s_irq |=> pcOut == 13'h0004; endproperty
	property p_jump; !irqTake && branchEn ##1 instrValid |=> pcOut == $past(branchAddr, 2);
	endproperty
	property p_gap; instrValid |=> !instrValid [*3] ##1 instrValid; endproperty
	property p_hold; instrValid |=> $stable(instrWord) [*3]; endproperty
	property p_cyc; $fell(instr_cycle_clock_out) |=> !instr_cycle_clock_out ##1
		instr_cycle_clock_out [*2] ##1 !instr_cycle_clock_out; endproperty
	property p_osc; $stable(rcMode) |-> osc_out == (rcMode && instr_cycle_clock_out); endproperty
	a_reset: assert property (p_reset) else $error("reset outputs wrong");
	a_first: assert property (p_first) else $error("first fetch wrong");
	a_step: assert property (p_step) else $error("counter step wrong");
	a_irq: assert property (p_irq) else $error("interrupt vector wrong");
	a_jump: assert property (p_jump) else $error("branch load wrong");
	a_gap: assert property (p_gap) else $error("fetch spacing wrong");
	a_hold: assert property (p_hold) else $error("word not held");
	a_cyc: assert property (p_cyc) else $error("cycle clock wrong");
	a_osc: assert property (p_osc) else $error("oscillator output wrong");
endmodule // pfa_fetch_mon
`default_nettype wire

// ==== pfa_program_fetch_bench.sv ====
// Testbench for the program fetch block
`timescale 1ns/10ps
`default_nettype none
module pfa_program_fetch_bench;
	logic sys_clk, srst, master_clear_n, rcMode, irqTake, branchEn, progWrEn, eePtrWrEn, eeWrEn;
	logic [12:0] branchAddr, pcOut;
	logic [9:0] progWrAddr;
	logic [13:0] progWrData, instrWord;
	logic [5:0] eePtrData;
	logic [7:0] eeWrData, eeRdData;
	logic instrValid, osc_out, instr_cycle_clock_out;
	int failures, checks_done;
	pfa_program_fetch u_pfa_program_fetch (.*);
	pfa_prog_loader u_pfa_prog_loader (.*);
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic stop_test;
		$display("failures %0d checks_done %0d", failures, checks_done);
		if (failures == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [13:0] e, logic [13:0] s);
		checks_done++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, s);
		end
	endtask
	// Wait for a fetch pulse, bounded
	task automatic sync_valid;
		int i;
		for (i = 0; i < 9 && instrValid !== 1'b1; i++) @(negedge sys_clk);
		if (i == 9) begin
			failures++;
			stop_test();
		end
	endtask
	task automatic fetch(logic [12:0] a);
		sync_valid();
		chk("pc", {1'b0, a}, {1'b0, pcOut});
		chk("word", {a[3:0], a[9:0]}, instrWord);
		@(negedge sys_clk);
	endtask
	task automatic jump(logic irq, logic [12:0] a, logic [12:0] t);
		irqTake = irq;
		branchEn = 1'b1;
		branchAddr = a;
		@(negedge sys_clk);
		sync_valid();
		{irqTake, branchEn} = 2'b00;
		@(negedge sys_clk);
		fetch(t);
	endtask
	task automatic ee(logic [5:0] p, logic [7:0] d, logic w, logic [7:0] e);
		eePtrData = p;
		eePtrWrEn = 1'b1;
		@(negedge sys_clk);
		{eePtrWrEn, eeWrData, eeWrEn} = {1'b0, d, w};
		@(negedge sys_clk);
		eeWrEn = 1'b0;
		repeat (3) @(negedge sys_clk);
		chk("ee", {6'h00, e}, {6'h00, eeRdData});
	endtask
	initial begin
		{rcMode, irqTake, branchEn, eePtrWrEn, eeWrEn, failures, checks_done} = '0;
		{branchAddr, eePtrData, eeWrData, master_clear_n, srst} = {27'h0, 2'b11};
		repeat (5) @(negedge sys_clk);
		srst = 1'b0;
		fetch(13'h0000);
		fetch(13'h0001);
		rcMode = 1'b1;
		ee(6'h3F, 8'hA5, 1'b1, 8'hA5);
		ee(6'h00, 8'h5A, 1'b1, 8'h5A);
		ee(6'h3F, 8'h00, 1'b0, 8'hA5);
		repeat (1030) @(negedge sys_clk);
		jump(1'b0, 13'h0420, 13'h0420);
		jump(1'b0, 13'h1FFF, 13'h1FFF);
		fetch(13'h0000);
		jump(1'b1, 13'h0ABC, 13'h0004);
		master_clear_n = 1'b0;
		repeat (3) @(negedge sys_clk);
		master_clear_n = 1'b1;
		fetch(13'h0000);
		stop_test();
	end
endmodule // pfa_program_fetch_bench
bind pfa_program_fetch pfa_fetch_mon u_pfa_fetch_mon (.*);
`default_nettype wire
